// ### include/activity_pkg.sv
// Function
// - only the voice-band level is watched; wake needs level and duration
// - absolute and relative comparisons run side by side; either may wake
// - wake rises when conditions are met and stays high while they hold
// - wake falls once the stimulus drops below the conditions
// - 13-bit absolute level split over a low byte and a high byte
// - absolute code maps monotonically to sound level, same scale as input
// - at or above floor plus margin, threshold is background plus margin
// - below floor plus margin, threshold is fixed at floor plus margin
// - margin code maps monotonically to an offset above the base level
// - floor code uses the same level scale as the absolute code
// - two-bit select: 1 clocked, 2 clockless, 0 disabled
// - clocked variant keeps the bitstream on; clockless turns it off
// - relative margin lives in one 8-bit byte written by the host
// - stimulus must persist for a programmable minimum duration per path
package activity_pkg;
  // register addresses
  localparam logic [7:0] ADDR_SELECT     = 8'h29;
  localparam logic [7:0] ADDR_FLOOR_HI   = 8'h2a;
  localparam logic [7:0] ADDR_FLOOR_LO   = 8'h2b;
  localparam logic [7:0] ADDR_REL_DUR_LO = 8'h2e;
  localparam logic [7:0] ADDR_DUR_HI     = 8'h2f;
  localparam logic [7:0] ADDR_ABS_DUR_LO = 8'h30;
  localparam logic [7:0] ADDR_ABS_LO     = 8'h31;
  localparam logic [7:0] ADDR_ABS_HI     = 8'h32;
  localparam logic [7:0] ADDR_MARGIN     = 8'h33;
  localparam logic [7:0] ADDR_STATUS     = 8'h34;

  localparam int LEVEL_W = 13;
  localparam int DUR_W   = 12;
  localparam int TH_W    = 17;

  // select codes
  localparam logic [1:0] SEL_OFF       = 2'h0;
  localparam logic [1:0] SEL_CLOCKED   = 2'h1;
  localparam logic [1:0] SEL_CLOCKLESS = 2'h2;

  // field positions
  localparam int SELECT_MSB      = 1;
  localparam int FLOOR_HI_MSB    = 4;
  localparam int REL_DUR_HI_MSB  = 3;
  localparam int ABS_DUR_HI_LSB  = 4;
  localparam int ABS_DUR_HI_MSB  = 7;
  localparam int STAT_ACTIVE     = 0;
  localparam int STAT_ABS        = 1;
  localparam int STAT_REL        = 2;
  localparam int STAT_WAKE       = 3;

  // reset values
  localparam logic [12:0] ABS_RESET    = 13'h07bc;
  localparam logic [12:0] FLOOR_RESET  = 13'h000f;
  localparam logic [7:0]  MARGIN_RESET = 8'h24;
  localparam logic [11:0] DUR_RESET    = 12'h000;

  // arithmetic shifts
  localparam int MARGIN_SHIFT = 5;
  localparam int AVG_SHIFT    = 4;

  // duration step time and its cycle count
  localparam int CLK_PERIOD_NS   = 40;
  localparam int DUR_STEP_NS     = 96000;
  localparam int DUR_STEP_CYCLES =
    (DUR_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TICK_W = 12;
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(DUR_STEP_CYCLES - 1);
endpackage

// ### verilog/duration_gate.sv
`timescale 1ns/10ps
module duration_gate
  import activity_pkg::*;
(
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  // timing
  input  wire logic             tick_i,
  input  wire logic             above_i,
  input  wire logic [DUR_W-1:0] min_i,
  // result
  output logic                  met_o
);
  typedef struct packed {
    logic [DUR_W-1:0] cnt;
    logic             met;
  } gate_t;

  gate_t st_reg;
  gate_t st_next;

  always_comb begin
    st_next = st_reg;
    if (!above_i) begin
      st_next.cnt = '0;
      st_next.met = 1'b0;
    end else begin
      if (tick_i && st_reg.cnt != '1) begin
        st_next.cnt = st_reg.cnt + DUR_W'(1);
      end
      st_next.met = st_reg.cnt >= min_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign met_o = st_reg.met;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  gate_rise_a: assert property ($rose(met_o) |->
    $past(above_i) && $past(st_reg.cnt) >= $past(min_i))
    else $error("duration met before minimum count");
  gate_drop_a: assert property (!above_i |=>
    !met_o && st_reg.cnt == '0)
    else $error("duration gate not cleared when level dropped");
endmodule

// ### verilog/activity_detect.sv
`timescale 1ns/10ps
module activity_detect
  import activity_pkg::*;
(
  // clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_n_i,
  // decoded one-wire configuration writes
  input  wire logic               wr_en_i,
  input  wire logic [7:0]         wr_addr_i,
  input  wire logic [7:0]         wr_data_i,
  // register readback
  input  wire logic [7:0]         rd_addr_i,
  output logic      [7:0]         rd_data_o,
  // voice-band filtered level samples
  input  wire logic               level_valid_i,
  input  wire logic [LEVEL_W-1:0] level_i,
  // outputs
  output logic                    wake_o,
  output logic                    pdm_en_o
);
  typedef struct packed {
    logic [1:0]         sel;
    logic [LEVEL_W-1:0] abs_code;
    logic [LEVEL_W-1:0] floor_code;
    logic [7:0]         margin;
    logic [DUR_W-1:0]   rel_dur;
    logic [DUR_W-1:0]   abs_dur;
    logic [LEVEL_W-1:0] level;
    logic [LEVEL_W-1:0] bg;
    logic [TICK_W-1:0]  tick_cnt;
    logic               tick;
    logic               wake;
    logic               pdm_en;
    logic [7:0]         rd_data;
  } state_t;

  state_t st_reg;
  state_t st_next;

  logic              active;
  logic [TH_W-1:0]   floor_th;
  logic [TH_W-1:0]   bg_th;
  logic [TH_W-1:0]   inst_th;
  logic [TH_W-1:0]   level_wide;
  logic [1:0]        above;
  logic [1:0]        met;
  logic [DUR_W-1:0]  min_dur [2];
  logic              abs_met;
  logic              rel_met;

  // base level raised by the margin code
  function automatic logic [TH_W-1:0] add_margin(
    input logic [LEVEL_W-1:0] base,
    input logic [7:0]         m
  );
    logic [20:0] prod;
    prod = 21'(base) * 21'(m);
    return TH_W'(base) + TH_W'(prod >> MARGIN_SHIFT);
  endfunction

  assign active = st_reg.sel == SEL_CLOCKED ||
                  st_reg.sel == SEL_CLOCKLESS;
  assign level_wide = TH_W'(st_reg.level);
  assign floor_th = add_margin(st_reg.floor_code, st_reg.margin);
  assign bg_th    = add_margin(st_reg.bg, st_reg.margin);

  always_comb begin
    if (level_wide >= floor_th) begin
      inst_th = bg_th;
    end else begin
      inst_th = floor_th;
    end
  end

  // both paths compared in parallel on the same level
  assign above[0] = active && st_reg.level > st_reg.abs_code;
  assign above[1] = active && level_wide > inst_th;
  assign min_dur[0] = st_reg.abs_dur;
  assign min_dur[1] = st_reg.rel_dur;

  generate
    for (genvar g = 0; g < 2; g++) begin : g_path
      duration_gate u_gate (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .tick_i  (st_reg.tick),
        .above_i (above[g]),
        .min_i   (min_dur[g]),
        .met_o   (met[g])
      );
    end
  endgenerate

  assign abs_met = met[0];
  assign rel_met = met[1];

  always_comb begin
    st_next = st_reg;
    // duration tick divider
    st_next.tick = 1'b0;
    if (st_reg.tick_cnt == TICK_LAST) begin
      st_next.tick_cnt = '0;
      st_next.tick     = 1'b1;
    end else begin
      st_next.tick_cnt = st_reg.tick_cnt + TICK_W'(1);
    end
    // configuration writes
    if (wr_en_i) begin
      case (wr_addr_i)
        ADDR_SELECT:     st_next.sel = wr_data_i[SELECT_MSB:0];
        ADDR_FLOOR_HI:   st_next.floor_code[12:8] =
                           wr_data_i[FLOOR_HI_MSB:0];
        ADDR_FLOOR_LO:   st_next.floor_code[7:0] = wr_data_i;
        ADDR_REL_DUR_LO: st_next.rel_dur[7:0] = wr_data_i;
        ADDR_DUR_HI: begin
          st_next.rel_dur[11:8] = wr_data_i[REL_DUR_HI_MSB:0];
          st_next.abs_dur[11:8] =
            wr_data_i[ABS_DUR_HI_MSB:ABS_DUR_HI_LSB];
        end
        ADDR_ABS_DUR_LO: st_next.abs_dur[7:0] = wr_data_i;
        ADDR_ABS_LO:     st_next.abs_code[7:0] = wr_data_i;
        ADDR_ABS_HI:     st_next.abs_code[12:8] =
                           wr_data_i[FLOOR_HI_MSB:0];
        ADDR_MARGIN:     st_next.margin = wr_data_i;
        default:         st_next.sel = st_reg.sel;
      endcase
    end
    // sample capture and background average
    if (level_valid_i) begin
      st_next.level = level_i;
      if (active) begin
        if (level_i >= st_reg.bg) begin
          st_next.bg = st_reg.bg + ((level_i - st_reg.bg) >> AVG_SHIFT);
        end else begin
          st_next.bg = st_reg.bg - ((st_reg.bg - level_i) >> AVG_SHIFT);
        end
      end
    end
    st_next.wake   = active && (abs_met || rel_met);
    st_next.pdm_en = st_reg.sel == SEL_CLOCKED;
    // readback
    case (rd_addr_i)
      ADDR_SELECT:     st_next.rd_data = {6'h00, st_reg.sel};
      ADDR_FLOOR_HI:   st_next.rd_data = {3'h0, st_reg.floor_code[12:8]};
      ADDR_FLOOR_LO:   st_next.rd_data = st_reg.floor_code[7:0];
      ADDR_REL_DUR_LO: st_next.rd_data = st_reg.rel_dur[7:0];
      ADDR_DUR_HI:     st_next.rd_data = {st_reg.abs_dur[11:8],
                                          st_reg.rel_dur[11:8]};
      ADDR_ABS_DUR_LO: st_next.rd_data = st_reg.abs_dur[7:0];
      ADDR_ABS_LO:     st_next.rd_data = st_reg.abs_code[7:0];
      ADDR_ABS_HI:     st_next.rd_data = {3'h0, st_reg.abs_code[12:8]};
      ADDR_MARGIN:     st_next.rd_data = st_reg.margin;
      ADDR_STATUS: begin
        st_next.rd_data              = 8'h00;
        st_next.rd_data[STAT_ACTIVE] = active;
        st_next.rd_data[STAT_ABS]    = abs_met;
        st_next.rd_data[STAT_REL]    = rel_met;
        st_next.rd_data[STAT_WAKE]   = st_reg.wake;
      end
      default:         st_next.rd_data = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg            <= '0;
      st_reg.sel        <= SEL_OFF;
      st_reg.abs_code   <= ABS_RESET;
      st_reg.floor_code <= FLOOR_RESET;
      st_reg.margin     <= MARGIN_RESET;
      st_reg.rel_dur    <= DUR_RESET;
      st_reg.abs_dur    <= DUR_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign wake_o    = st_reg.wake;
  assign pdm_en_o  = st_reg.pdm_en;
  assign rd_data_o = st_reg.rd_data;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence abs_hi_write;
    wr_en_i && wr_addr_i == ADDR_ABS_HI;
  endsequence
  sequence margin_write;
    wr_en_i && wr_addr_i == ADDR_MARGIN;
  endsequence

  wake_rise_a: assert property ($rose(wake_o) |->
    $past(active) && ($past(abs_met) || $past(rel_met)))
    else $error("wake rose without a met path");
  wake_hold_a: assert property (active && (abs_met || rel_met) |=>
    wake_o)
    else $error("wake low while a path is met");
  wake_fall_a: assert property (!abs_met && !rel_met |=> !wake_o)
    else $error("wake high with no path met");
  idle_quiet_a: assert property (!active |=> !wake_o)
    else $error("wake high while disabled");
  static_th_a: assert property (level_wide < floor_th |->
    inst_th == floor_th)
    else $error("threshold not fixed below floor");
  dynamic_th_a: assert property (level_wide >= floor_th |->
    inst_th == bg_th)
    else $error("threshold not tracking background");
  abs_hi_a: assert property (abs_hi_write |=>
    st_reg.abs_code[12:8] == $past(wr_data_i[FLOOR_HI_MSB:0]))
    else $error("absolute level high byte not stored");
  margin_wr_a: assert property (margin_write ##1 !wr_en_i |=>
    st_reg.margin == $past(wr_data_i, 2))
    else $error("margin byte not stored");
  bitstream_sel_a: assert property (1'b1 |=>
    pdm_en_o == ($past(st_reg.sel) == SEL_CLOCKED))
    else $error("bitstream enable does not follow select");
  bg_rise_a: assert property (level_valid_i && active &&
    level_i > st_reg.bg |=> st_reg.bg >= $past(st_reg.bg))
    else $error("background fell on a louder sample");
endmodule

// ### bench/host_model.sv
`timescale 1ns/10ps
module host_model
  import activity_pkg::*;
(
  // clock
  input  wire logic       clk_i,
  // configuration writes and readback
  output logic            wr_en_o,
  output logic [7:0]      wr_addr_o,
  output logic [7:0]      wr_data_o,
  output logic [7:0]      rd_addr_o,
  input  wire logic [7:0] rd_data_i
);
  task automatic idle;
    wr_en_o = 1'b0;
    wr_addr_o = 8'h00;
    wr_data_o = 8'h00;
    rd_addr_o = 8'h00;
  endtask
  // one-cycle write; released lines carry the inverse
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_en_o <= 1'b1;
    wr_addr_o <= a;
    wr_data_o <= d;
    @(posedge clk_i);
    wr_en_o <= 1'b0;
    wr_addr_o <= ~a;
    wr_data_o <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    rd_addr_o <= a;
    repeat (2) @(posedge clk_i);
    #1 d = rd_data_i;
  endtask
  // 13-bit level codes clamped to their span, low byte then high byte
  task automatic wr13(input logic [7:0] lo, input logic [7:0] hi,
                      input logic [12:0] c);
    logic [12:0] k;
    k = (c < 13'h00f) ? 13'h00f : (c > 13'h7bc) ? 13'h7bc : c;
    wr(lo, k[7:0]);
    wr(hi, {3'h0, k[12:8]});
  endtask
  task automatic margin(input logic [7:0] m);
    wr(ADDR_MARGIN, (m < 8'h24) ? 8'h24 : m);
  endtask
  task automatic sel(input logic [1:0] s);
    wr(ADDR_SELECT, {6'h00, s});
  endtask
  task automatic dur(input logic [11:0] r, input logic [11:0] a);
    logic [11:0] k;
    k = (r > 12'h12c) ? 12'h12c : r;
    wr(ADDR_REL_DUR_LO, k[7:0]);
    wr(ADDR_DUR_HI, {a[11:8], k[11:8]});
    wr(ADDR_ABS_DUR_LO, a[7:0]);
  endtask
endmodule

// ### bench/tb_activity_detect.sv
`timescale 1ns/10ps
module tb_activity_detect
  import activity_pkg::*;
;
  logic               clk_i = 1'b0;
  logic               rst_n_i;
  logic               wr_en_i;
  logic [7:0]         wr_addr_i;
  logic [7:0]         wr_data_i;
  logic [7:0]         rd_addr_i;
  logic [7:0]         rd_data_o;
  logic               level_valid_i;
  logic [LEVEL_W-1:0] level_i;
  logic               wake_o;
  logic               pdm_en_o;
  logic [7:0]         rv;
  logic [15:0]        lfsr;
  logic [12:0]        abs_c;
  logic [12:0]        lv;
  logic [12:0]        ft;
  int                 miscompares;
  int                 n_checks;
  logic [7:0]         ra [10] = '{8'h31, 8'h32, 8'h2a, 8'h2b, 8'h33,
                                  8'h29, 8'h2e, 8'h2f, 8'h30, 8'h40};
  logic [7:0]         re [10] = '{8'hbc, 8'h07, 8'h00, 8'h0f, 8'h24,
                                  8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

  activity_detect activity_detect_inst (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .wr_en_i(wr_en_i),
    .wr_addr_i(wr_addr_i), .wr_data_i(wr_data_i), .rd_addr_i(rd_addr_i),
    .rd_data_o(rd_data_o), .level_valid_i(level_valid_i),
    .level_i(level_i), .wake_o(wake_o), .pdm_en_o(pdm_en_o));
  host_model host_model_inst (
    .clk_i(clk_i), .wr_en_o(wr_en_i), .wr_addr_o(wr_addr_i),
    .wr_data_o(wr_data_i), .rd_addr_o(rd_addr_i), .rd_data_i(rd_data_o));

  always #20 clk_i = ~clk_i;

  function automatic logic [15:0] lfsr_next(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  // base level raised by the margin code
  function automatic logic [12:0] m_th(input logic [12:0] b,
                                       input logic [7:0] m);
    return b + 13'((21'(b) * 21'(m)) >> 5);
  endfunction
  task automatic check(input logic [7:0] got, input logic [7:0] exp,
                       input string what);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic do_reset;
    rst_n_i <= 1'b0;
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
  endtask
  // one level sample, then wait out the compare, gate and wake stages
  task automatic sample(input logic [12:0] l);
    @(posedge clk_i);
    level_valid_i <= 1'b1;
    level_i <= l;
    @(posedge clk_i);
    level_valid_i <= 1'b0;
    level_i <= ~l;
    repeat (3) @(posedge clk_i);
    #1;
  endtask

  initial begin
    repeat (40000) @(posedge clk_i);
    miscompares++;
    give_verdict;
  end

  initial begin
    rst_n_i = 1'b0;
    level_valid_i = 1'b0;
    level_i = 13'h0000;
    host_model_inst.idle();
    miscompares = 0;
    n_checks = 0;
    lfsr = 16'h555e;
    do_reset;
    for (int i = 0; i < 10; i++) begin
      host_model_inst.rd(ra[i], rv);
      check(rv, re[i], "reset value");
    end
    check(wake_o, 1'b0, "reset wake");
    host_model_inst.margin(8'hff);
    host_model_inst.wr13(ADDR_FLOOR_LO, ADDR_FLOOR_HI, 13'h7bc);
    host_model_inst.wr(ADDR_ABS_HI, 8'he1);
    host_model_inst.wr(ADDR_ABS_LO, 8'h13);
    host_model_inst.rd(ADDR_ABS_HI, rv);
    check(rv, 8'h01, "abs high byte");
    host_model_inst.wr(ADDR_STATUS, 8'hff);
    for (int s = 0; s < 4; s++) begin
      host_model_inst.sel(2'(s));
      host_model_inst.rd(ADDR_SELECT, rv);
      check(rv, 8'(s), "select");
      check(pdm_en_o, s == 1, "bitstream");
      sample(13'h1fff);
      check(wake_o, s == 1 || s == 2, "wake high");
      sample(13'h0000);
      check(wake_o, 1'b0, "wake low");
    end
    host_model_inst.sel(SEL_CLOCKED);
    for (int i = 0; i < 24; i++) begin
      lfsr = lfsr_next(lfsr);
      abs_c = 13'h00f + 13'(lfsr % 16'd1966);
      lfsr = lfsr_next(lfsr);
      lv = (i % 3 == 0) ? abs_c : (i % 3 == 1) ? abs_c + 13'h1 : lfsr[12:0];
      host_model_inst.wr13(ADDR_ABS_LO, ADDR_ABS_HI, abs_c);
      sample(lv);
      check(wake_o, lv > abs_c, "absolute path");
    end
    sample(13'h1fff);
    host_model_inst.rd(ADDR_STATUS, rv);
    check(rv, 8'h0b, "status");
    sample(13'h0000);
    host_model_inst.dur(12'h000, 12'h002);
    sample(13'h1fff);
    check(wake_o, 1'b0, "early wake");
    for (int i = 0; i < 6000 && wake_o !== 1'b1; i++) @(posedge clk_i);
    #1 check(wake_o, 1'b1, "held wake");
    @(posedge clk_i);
    do_reset;
    host_model_inst.sel(SEL_CLOCKLESS);
    repeat (2) @(posedge clk_i);
    #1 check(pdm_en_o, 1'b0, "clockless bitstream");
    ft = m_th(13'h00f, 8'h24);
    sample(ft - 13'h1);
    check(wake_o, 1'b0, "below floor");
    sample(ft);
    check(wake_o, 1'b1, "at floor");
    for (int i = 0; i < 150; i++) sample(13'h190);
    check(wake_o, 1'b0, "background caught up");
    host_model_inst.dur(12'h002, 12'h000);
    sample(13'h0700);
    check(wake_o, 1'b0, "early relative wake");
    for (int i = 0; i < 6000 && wake_o !== 1'b1; i++) @(posedge clk_i);
    #1 check(wake_o, 1'b1, "relative wake");
    give_verdict;
  end
endmodule
